// ### src/flash_subsector_erase_uid_call.sv
// System-call engine for subsector erase and unique identification read
`timescale 1ns/1ps
`default_nettype none
`include "flash_call_params.svh"
module flash_subsector_erase_uid_call #(
  parameter int ROW_BYTES    = `ROW_BYTES,
  parameter int ROWS_PER_SUB = `ROWS_PER_SUB
) (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic [3:0]                 avsAddress,
  input  wire logic                       avsRead,
  input  wire logic                       avsWrite,
  input  wire logic [31:0]                avsWriteData,
  input  wire logic [3:0]                 avsByteEnable,
  output logic [31:0]                     avsReadData,
  output logic                            avsWaitRequest,
  output flash_call_pkg::mem_cmd_t        memCmd,
  input  wire flash_call_pkg::mem_rsp_t   memRsp,
  output flash_call_pkg::erase_cmd_t      eraseCmd,
  input  wire flash_call_pkg::flash_rsp_t eraseRsp,
  output flash_call_pkg::uid_cmd_t        uidCmd,
  input  wire flash_call_pkg::flash_rsp_t uidRsp,
  output logic                            cpuBlock,
  output logic                            callBusy
);
  import flash_call_pkg::*;

  localparam int SUB_BYTES = ROW_BYTES * ROWS_PER_SUB;

  typedef struct packed {
    call_state_t state;
    logic [31:0] ptr;
    logic [31:0] cmdWord;
    logic [31:0] target;
    logic [31:0] result;
    logic [31:0] idA;
    logic [31:0] idB;
    logic        resultValid;
    logic        busy;
    logic        block;
    mem_cmd_t    mem;
    erase_cmd_t  erase;
    uid_cmd_t    uid;
  } core_state_t;

  core_state_t st_ff;
  core_state_t nxt_st;
  logic        startPulse;
  logic [31:0] startPtr;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [31:0] okWord(input logic [27:0] payload);
    return {`ST_OK, payload};
  endfunction : okWord

  function automatic logic [31:0] errWord(input logic [27:0] code);
    return {`ST_ERR, code};
  endfunction : errWord

  function automatic mem_cmd_t memRead(input logic [31:0] addr);
    return '{req: 1'b1, write: 1'b0, addr: addr, wdata: 32'h0000_0000};
  endfunction : memRead

  function automatic mem_cmd_t memWrite(input logic [31:0] addr, input logic [31:0] data);
    return '{req: 1'b1, write: 1'b1, addr: addr, wdata: data};
  endfunction : memWrite

  function automatic logic [31:0] subBase(input logic [31:0] addr);
    // Any byte of the subsector selects it; the low bits are dropped
    return addr & ~(SUB_BYTES[31:0] - 32'h0000_0001);
  endfunction : subBase

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Register front end

  call_regs u_regs (
    .clk            (clk),
    .nrst           (nrst),
    .avsAddress     (avsAddress),
    .avsRead        (avsRead),
    .avsWrite       (avsWrite),
    .avsWriteData   (avsWriteData),
    .avsByteEnable  (avsByteEnable),
    .avsReadData    (avsReadData),
    .avsWaitRequest (avsWaitRequest),
    .busy           (st_ff.busy),
    .blocking       (st_ff.block),
    .resultValid    (st_ff.resultValid),
    .resultWord     (st_ff.result),
    .startPulse     (startPulse),
    .startPtr       (startPtr)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Call sequencer

  always_comb begin
    nxt_st = st_ff;
    nxt_st.resultValid = 1'b0;
    unique case (st_ff.state)
      S_IDLE: begin
        if (startPulse) begin
          nxt_st.ptr = startPtr;
          nxt_st.busy = 1'b1;
          // A misaligned pointer is answered with an error status written to its aligned word; no command is read
          if (startPtr[1:0] != 2'b00) begin
            nxt_st.result = errWord(`ERR_ALIGN);
            nxt_st.state = S_WRSTAT;
            nxt_st.mem = memWrite(startPtr & 32'hFFFF_FFFC, errWord(`ERR_ALIGN));
          end else begin
            nxt_st.state = S_RDCMD;
            nxt_st.mem = memRead(startPtr);
          end
        end
      end
      S_RDCMD: begin
        if (memRsp.ack) begin
          nxt_st.mem.req = 1'b0;
          nxt_st.cmdWord = memRsp.rdata;
          unique case (memRsp.rdata[`OPC_HI:`OPC_LO])
            `OP_ERASE_SUB: begin
              // Bits 23:16 never reach any decision here
              nxt_st.block = (memRsp.rdata[`BLK_HI:`BLK_LO] == `BLOCK_CODE);
              nxt_st.state = S_RDADDR;
              nxt_st.mem = memRead(st_ff.ptr + `OFS_PARAM1);
            end
            `OP_READ_UID: begin
              // Only the opcode byte is decoded; bits 15:0 are don't care
              nxt_st.state = S_UIDLOT;
              nxt_st.uid = '{req: 1'b1, index: `UID_LOT};
            end
            default: begin
              nxt_st.result = errWord(`ERR_OPCODE);
              nxt_st.state = S_WRSTAT;
              nxt_st.mem = memWrite(st_ff.ptr, errWord(`ERR_OPCODE));
            end
          endcase
        end
      end
      S_RDADDR: begin
        if (memRsp.ack) begin
          nxt_st.mem.req = 1'b0;
          nxt_st.target = memRsp.rdata;
          nxt_st.state = S_ERASE;
          nxt_st.erase.req = 1'b1;
          nxt_st.erase.base = subBase(memRsp.rdata);
          nxt_st.erase.hwHv = st_ff.cmdWord[`HWHV_BIT];
          nxt_st.erase.stallAll = st_ff.cmdWord[`STALL_BIT];
        end
      end
      S_ERASE: begin
        // Request is held as a level until the flash controller answers
        if (eraseRsp.ack) begin
          nxt_st.erase.req = 1'b0;
          nxt_st.erase.stallAll = 1'b0;
          nxt_st.result = eraseRsp.fail ? errWord(`ERR_ERASE) : okWord(28'h000_0000);
          nxt_st.state = S_WRSTAT;
          nxt_st.mem = memWrite(st_ff.ptr, nxt_st.result);
        end
      end
      S_UIDLOT: begin
        if (uidRsp.ack) begin
          nxt_st.uid.req = 1'b0;
          if (uidRsp.fail) begin
            nxt_st.result = errWord(`ERR_SUPERVISORY_FLASH);
            nxt_st.state = S_WRSTAT;
            nxt_st.mem = memWrite(st_ff.ptr, errWord(`ERR_SUPERVISORY_FLASH));
          end else begin
            nxt_st.result = okWord(uidRsp.data[`LOT_HI:0]);
            nxt_st.state = S_UIDA;
            nxt_st.uid = '{req: 1'b1, index: `UID_A};
          end
        end
      end
      S_UIDA: begin
        if (uidRsp.ack) begin
          nxt_st.uid.req = 1'b0;
          nxt_st.idA = uidRsp.data;
          if (uidRsp.fail) begin
            nxt_st.result = errWord(`ERR_SUPERVISORY_FLASH);
            nxt_st.state = S_WRSTAT;
            nxt_st.mem = memWrite(st_ff.ptr, errWord(`ERR_SUPERVISORY_FLASH));
          end else begin
            nxt_st.state = S_UIDB;
            nxt_st.uid = '{req: 1'b1, index: `UID_B};
          end
        end
      end
      S_UIDB: begin
        if (uidRsp.ack) begin
          nxt_st.uid.req = 1'b0;
          nxt_st.idB = uidRsp.data;
          if (uidRsp.fail) begin
            nxt_st.result = errWord(`ERR_SUPERVISORY_FLASH);
          end
          nxt_st.state = S_WRSTAT;
          nxt_st.mem = memWrite(st_ff.ptr, uidRsp.fail ? errWord(`ERR_SUPERVISORY_FLASH) : st_ff.result);
        end
      end
      S_WRSTAT: begin
        if (memRsp.ack) begin
          nxt_st.mem.req = 1'b0;
          // Identifier words follow only after a good identification read
          if ((st_ff.cmdWord[`OPC_HI:`OPC_LO] == `OP_READ_UID) &&
              (st_ff.result[31:28] == `ST_OK) && (st_ff.ptr[1:0] == 2'b00)) begin
            nxt_st.state = S_WRIDA;
            nxt_st.mem = memWrite(st_ff.ptr + `OFS_PARAM1, st_ff.idA);
          end else begin
            nxt_st.state = S_FINISH;
          end
        end
      end
      S_WRIDA: begin
        if (memRsp.ack) begin
          nxt_st.state = S_WRIDB;
          nxt_st.mem = memWrite(st_ff.ptr + `OFS_PARAM2, st_ff.idB);
        end
      end
      S_WRIDB: begin
        if (memRsp.ack) begin
          nxt_st.mem.req = 1'b0;
          nxt_st.state = S_FINISH;
        end
      end
      S_FINISH: begin
        // Status word is mirrored into the message data word as the call ends
        nxt_st.resultValid = 1'b1;
        nxt_st.busy = 1'b0;
        nxt_st.block = 1'b0;
        nxt_st.state = S_IDLE;
      end
    endcase
    if (~nrst) begin
      nxt_st.state = S_IDLE;
      nxt_st.ptr = 32'h0000_0000;
      nxt_st.cmdWord = 32'h0000_0000;
      nxt_st.target = 32'h0000_0000;
      nxt_st.result = 32'h0000_0000;
      nxt_st.idA = 32'h0000_0000;
      nxt_st.idB = 32'h0000_0000;
      nxt_st.resultValid = 1'b0;
      nxt_st.busy = 1'b0;
      nxt_st.block = 1'b0;
      nxt_st.mem = '{req: 1'b0, write: 1'b0, addr: 32'h0000_0000, wdata: 32'h0000_0000};
      nxt_st.erase = '{req: 1'b0, hwHv: 1'b0, stallAll: 1'b0, base: 32'h0000_0000};
      nxt_st.uid = '{req: 1'b0, index: 2'h0};
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign memCmd   = st_ff.mem;
  assign eraseCmd = st_ff.erase;
  assign uidCmd   = st_ff.uid;
  assign cpuBlock = st_ff.block;
  assign callBusy = st_ff.busy;

endmodule : flash_subsector_erase_uid_call
`default_nettype wire

// ### src/flash_call_params.svh
// Constants for the subsector erase and unique identification call engine
`ifndef FLASH_CALL_PARAMS_SVH
`define FLASH_CALL_PARAMS_SVH
`define OP_ERASE_SUB   8'h1D
`define OP_READ_UID    8'h1F
`define BLOCK_CODE     8'h01
`define ST_OK          4'hA
`define ST_ERR         4'hF
`define OPC_HI         31
`define OPC_LO         24
`define BLK_HI         15
`define BLK_LO         8
`define STALL_BIT      2
`define HWHV_BIT       1
`define LOT_HI         27
`define OFS_PARAM1     32'h0000_0004
`define OFS_PARAM2     32'h0000_0008
`define ERR_ALIGN      28'h000_0001
`define ERR_OPCODE     28'h000_0002
`define ERR_ERASE      28'h000_0003
`define ERR_SUPERVISORY_FLASH     28'h000_0004
`define ERR_MEMORY     28'h000_0005
`define ROW_BYTES      512
`define ROWS_PER_SUB   8
`define REG_MSG        4'h0
`define REG_STAT       4'h4
`define STAT_BUSY      0
`define STAT_DONE      1
`define STAT_BLOCK     2
`define UID_LOT        2'h0
`define UID_A          2'h1
`define UID_B          2'h2
`endif

// ### src/flash_call_pkg.sv
// Types shared by the call engine, its port checkers and its bench models
package flash_call_pkg;
  typedef enum logic [10:0] {
    S_IDLE   = 11'h001,
    S_RDCMD  = 11'h002,
    S_RDADDR = 11'h004,
    S_ERASE  = 11'h008,
    S_UIDLOT = 11'h010,
    S_UIDA   = 11'h020,
    S_UIDB   = 11'h040,
    S_WRSTAT = 11'h080,
    S_WRIDA  = 11'h100,
    S_WRIDB  = 11'h200,
    S_FINISH = 11'h400
  } call_state_t;
  typedef struct packed {
    logic        req;
    logic        write;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_cmd_t;
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } mem_rsp_t;
  typedef struct packed {
    logic        req;
    logic        hwHv;
    logic        stallAll;
    logic [31:0] base;
  } erase_cmd_t;
  typedef struct packed {
    logic       req;
    logic [1:0] index;
  } uid_cmd_t;
  typedef struct packed {
    logic        ack;
    logic        fail;
    logic [31:0] data;
  } flash_rsp_t;
endpackage : flash_call_pkg

// ### src/call_regs.sv
// Avalon-MM register front end holding the message data word and call status
`timescale 1ns/1ps
`default_nettype none
`include "flash_call_params.svh"
module call_regs (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [31:0] avsWriteData,
  input  wire logic [3:0]  avsByteEnable,
  output logic [31:0]      avsReadData,
  output logic             avsWaitRequest,
  input  wire logic        busy,
  input  wire logic        blocking,
  input  wire logic        resultValid,
  input  wire logic [31:0] resultWord,
  output logic             startPulse,
  output logic [31:0]      startPtr
);
  import flash_call_pkg::*;
  typedef struct packed {
    logic        waitReq;
    logic [31:0] readData;
    logic [31:0] msgData;
    logic        done;
    logic        start;
  } regs_state_t;
  regs_state_t st_ff;
  regs_state_t nxt_st;
  logic        acc;
  logic [31:0] merged;
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    return old;
  endfunction : mergeBytes
  always_comb begin
    nxt_st = st_ff;
    nxt_st.start = 1'b0;
    acc = (avsRead | avsWrite) & ~st_ff.waitReq;
    merged = mergeBytes(st_ff.msgData, avsWriteData, avsByteEnable);
    // One wait state: waitrequest drops for the single completing cycle
    nxt_st.waitReq = ~((avsRead | avsWrite) & st_ff.waitReq);
    if (avsRead & st_ff.waitReq) begin
      unique case (avsAddress)
        `REG_MSG:  nxt_st.readData = st_ff.msgData;
        `REG_STAT: nxt_st.readData = {29'h000_0000, blocking, st_ff.done, busy};
        default:   nxt_st.readData = 32'h0000_0000;
      endcase
    end
    if (acc & avsWrite & (avsAddress == `REG_MSG) & ~busy & ~st_ff.start) begin
      nxt_st.msgData = merged;
      nxt_st.start = 1'b1;
    end
    if (acc & avsWrite & (avsAddress == `REG_STAT) & avsByteEnable[0] &
        avsWriteData[`STAT_DONE]) begin
      nxt_st.done = 1'b0;
    end
    // Result write-back and completion flag override a software access
    if (resultValid) begin
      nxt_st.msgData = resultWord;
      nxt_st.done = 1'b1;
    end
    if (~nrst) begin
      nxt_st = '{waitReq: 1'b1, readData: 32'h0000_0000, msgData: 32'h0000_0000,
                 done: 1'b0, start: 1'b0};
    end
  end
  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end
  assign avsReadData    = st_ff.readData;
  assign avsWaitRequest = st_ff.waitReq;
  assign startPulse     = st_ff.start;
  assign startPtr       = st_ff.msgData;
endmodule : call_regs
`default_nettype wire

// ### verif/flash_call_assertions.sv
// Concurrent checks on the ports of the call engine
`timescale 1ns/1ps
`default_nettype none
module flash_call_assertions #(
  parameter int ROW_BYTES    = 512,
  parameter int ROWS_PER_SUB = 8
) (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic                       avsRead,
  input wire logic                       avsWrite,
  input wire logic                       avsWaitRequest,
  input wire flash_call_pkg::mem_cmd_t   memCmd,
  input wire flash_call_pkg::mem_rsp_t   memRsp,
  input wire flash_call_pkg::erase_cmd_t eraseCmd,
  input wire flash_call_pkg::flash_rsp_t eraseRsp,
  input wire flash_call_pkg::uid_cmd_t   uidCmd,
  input wire flash_call_pkg::flash_rsp_t uidRsp,
  input wire logic                       cpuBlock,
  input wire logic                       callBusy
);
  import flash_call_pkg::*;
  localparam logic [31:0] SUB_MASK = ROW_BYTES * ROWS_PER_SUB - 1;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  wait_single_a: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low for more than one cycle");
  bus_answer_a: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus access not answered after one wait state");
  req_hold_a: assert property (memCmd.req && !memRsp.ack |=> memCmd.req && $stable(memCmd.addr))
    else $error("memory request dropped or changed before ack");
  mem_align_a: assert property (memCmd.req |-> memCmd.addr[1:0] == 2'b00)
    else $error("memory access not word aligned");
  erase_base_a: assert property (eraseCmd.req |-> (eraseCmd.base & SUB_MASK) == 32'h0)
    else $error("erase base not on a subsector boundary");
  stall_hold_a: assert property (eraseCmd.stallAll |-> eraseCmd.req)
    else $error("read stall outside an erase");
  busy_span_a: assert property (memCmd.req || eraseCmd.req || uidCmd.req |-> callBusy)
    else $error("request while call not busy");
  uid_noblock_a: assert property (uidCmd.req |-> !cpuBlock && uidCmd.index <= 2'd2)
    else $error("identification read blocks or bad index");
  block_end_a: assert property ($fell(callBusy) |-> ##[0:1] !cpuBlock)
    else $error("core still blocked after call end");
  uid_chain_a: assert property (uidCmd.req && uidRsp.ack && !uidRsp.fail && uidCmd.index == 2'd0
    |=> uidCmd.req && uidCmd.index == 2'd1)
    else $error("identifier read not chained");
  ok_write_a: assert property (eraseCmd.req && eraseRsp.ack && !eraseRsp.fail
    |-> ##[1:3] memCmd.req && memCmd.write && memCmd.wdata[31:28] == 4'hA)
    else $error("success status not written after erase");
  fail_write_a: assert property (uidCmd.req && uidRsp.ack && uidRsp.fail
    |-> ##[1:3] memCmd.req && memCmd.write && memCmd.wdata == 32'hF000_0004)
    else $error("error status not written after failed read");
  erase_c: cover property ($rose(eraseCmd.req));
  uid_c: cover property ($rose(uidCmd.req));
  block_c: cover property ($rose(cpuBlock));
endmodule : flash_call_assertions
bind flash_subsector_erase_uid_call flash_call_assertions #(
  .ROW_BYTES(ROW_BYTES), .ROWS_PER_SUB(ROWS_PER_SUB)
) u_chk (.clk(clk), .nrst(nrst), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsWaitRequest(avsWaitRequest), .memCmd(memCmd), .memRsp(memRsp), .eraseCmd(eraseCmd),
  .eraseRsp(eraseRsp), .uidCmd(uidCmd), .uidRsp(uidRsp), .cpuBlock(cpuBlock),
  .callBusy(callBusy));
`default_nettype wire

// ### verif/call_far_model.sv
// Behavioural parameter memory and flash responders facing the call engine
`timescale 1ns/1ps
`default_nettype none
module call_far_model #(
  parameter logic [31:0] LOT = 32'h0123_4567,
  parameter logic [31:0] IDA = 32'h89AB_CDEF,
  parameter logic [31:0] IDB = 32'h5A5A_C3C3
) (
  input  wire logic                       clk,
  input  wire flash_call_pkg::mem_cmd_t   memCmd,
  output var  flash_call_pkg::mem_rsp_t   memRsp,
  input  wire flash_call_pkg::erase_cmd_t eraseCmd,
  output var  flash_call_pkg::flash_rsp_t eraseRsp,
  input  wire flash_call_pkg::uid_cmd_t   uidCmd,
  output var  flash_call_pkg::flash_rsp_t uidRsp,
  input  wire logic                       failE,
  input  wire logic                       failU
);
  import flash_call_pkg::*;
  logic [31:0] mem [0:63];
  int          seed = 32'h5F21;
  initial {memRsp, eraseRsp, uidRsp} = '0;
  // Random gaps give both prompt and slow answers; idle data is inverted
  always @(posedge clk) begin
    logic [1:0]  r;
    logic        a;
    logic [31:0] d;
    r = 2'($random(seed));
    a = memCmd.req & ~memRsp.ack & r[0];
    memRsp <= '{a, a ? mem[memCmd.addr[7:2]] : ~memRsp.rdata};
    if (a && memCmd.write)
      mem[memCmd.addr[7:2]] <= memCmd.wdata;
    a = eraseCmd.req & ~eraseRsp.ack & r[1];
    eraseRsp <= '{a, a & failE, ~eraseRsp.data};
    a = uidCmd.req & ~uidRsp.ack & r[0];
    d = uidCmd.index == 2'd0 ? LOT : (uidCmd.index == 2'd1 ? IDA : IDB);
    uidRsp <= '{a, a & failU, a ? d : ~uidRsp.data};
  end
endmodule : call_far_model
`default_nettype wire

// ### verif/flash_subsector_erase_uid_call_tb.sv
// Self-checking bench for the subsector erase and identification call engine
`timescale 1ns/1ps
`default_nettype none
module flash_subsector_erase_uid_call_tb;
  import flash_call_pkg::*;
  localparam int          RB  = 64;
  localparam int          SUB = RB * 8;
  localparam logic [31:0] LOT = 32'h0BAD_F00D;
  localparam logic [31:0] IDA = 32'h1357_9BDF;
  localparam logic [31:0] IDB = 32'h2468_ACE0;
  logic        clk, nrst, avsRead, avsWrite, avsWaitRequest, cpuBlock, callBusy;
  logic        failE, failU, sawBlock;
  logic [3:0]  avsAddress;
  logic [31:0] avsWriteData, avsReadData;
  mem_cmd_t    memCmd;
  mem_rsp_t    memRsp;
  erase_cmd_t  eraseCmd, seenErase;
  uid_cmd_t    uidCmd;
  flash_rsp_t  eraseRsp, uidRsp;
  int          errorCnt, checked;
  int          seed = 32'h8703;
  flash_subsector_erase_uid_call #(.ROW_BYTES(RB), .ROWS_PER_SUB(8)) DUT (.clk(clk),
    .nrst(nrst), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(4'hF), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .memCmd(memCmd), .memRsp(memRsp), .eraseCmd(eraseCmd),
    .eraseRsp(eraseRsp), .uidCmd(uidCmd), .uidRsp(uidRsp), .cpuBlock(cpuBlock),
    .callBusy(callBusy));
  call_far_model #(.LOT(LOT), .IDA(IDA), .IDB(IDB)) M (.clk(clk), .memCmd(memCmd),
    .memRsp(memRsp), .eraseCmd(eraseCmd), .eraseRsp(eraseRsp), .uidCmd(uidCmd),
    .uidRsp(uidRsp), .failE(failE), .failU(failU));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (cpuBlock === 1'b1)
      sawBlock <= 1'b1;
    if (eraseCmd.req === 1'b1)
      seenErase <= eraseCmd;
  end
  function automatic logic [31:0] expect_word(logic [31:0] p, w0, logic fe, fu);
    if (p[1:0] != 2'b00)
      return 32'hF000_0001;
    case (w0[31:24])
      8'h1D: return fe ? 32'hF000_0003 : 32'hA000_0000;
      8'h1F: return fu ? 32'hF000_0004 : {4'hA, LOT[27:0]};
      default: return 32'hF000_0002;
    endcase
  endfunction : expect_word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Entered just after a rising edge; one idle edge follows each access
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic run_call(input logic [31:0] p, w0, tgt, input logic fe, fu);
    logic [31:0] q, e;
    int          n;
    e = expect_word(p, w0, fe, fu);
    failE <= fe;
    failU <= fu;
    M.mem[p[7:2]] = w0;
    M.mem[p[7:2] + 6'd1] = tgt;
    sawBlock = 1'b0;
    seenErase = '0;
    bus(1'b1, 4'h0, p, q);
    // A second start while busy must be ignored
    if (w0[31:24] == 8'h1D)
      bus(1'b1, 4'h0, 32'h0000_0040, q);
    n = 0;
    do begin
      bus(1'b0, 4'h4, 32'h0, q);
      n++;
    end while (q[1] !== 1'b1 && n < 300);
    chk(q[2:0], 3'b010);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, e);
    chk(M.mem[p[7:2]], e);
    if (e[31:28] == 4'hA && w0[31:24] == 8'h1F) begin
      chk(M.mem[p[7:2] + 6'd1], IDA);
      chk(M.mem[p[7:2] + 6'd2], IDB);
    end
    if (p[1:0] == 2'b00 && w0[31:24] == 8'h1D) begin
      chk(seenErase.base, tgt & ~32'(SUB - 1));
      chk({seenErase.hwHv, seenErase.stallAll}, {w0[1], w0[2]});
    end
    chk(sawBlock, w0[31:24] == 8'h1D && w0[15:8] == 8'h01 && p[1:0] == 2'b00);
    bus(1'b1, 4'h4, 32'h2, q);
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h0);
  endtask : run_call
  task automatic end_of_test();
    $display("errors %0d, checks %0d", errorCnt, checked);
    if (errorCnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    errorCnt++;
    end_of_test();
  end
  initial begin
    logic [31:0] q, w;
    {nrst, avsRead, avsWrite, failE, failU} = '0;
    {avsAddress, avsWriteData, errorCnt, checked} = '0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
    run_call(32'h2000_0012, 32'h1F00_0000, 32'h0, 1'b0, 1'b0);
    run_call(32'h2000_0020, 32'h1D00_0106, 32'h1000_0FFF, 1'b0, 1'b0);
    for (int i = 0; i < 18; i++) begin
      w = $random(seed);
      if (i % 4 != 3)
        w[31:24] = i % 2 ? 8'h1F : 8'h1D;
      if (i % 3 == 0)
        w[15:8] = 8'h01;
      run_call({24'h200000, 4'($random(seed)), 4'h0}, w, $random(seed),
               1'($random(seed)), 1'($random(seed)));
    end
    end_of_test();
  end
endmodule : flash_subsector_erase_uid_call_tb
`default_nettype wire
